// ---- dv/sreg_front_model.sv ----
`timescale 1ns/1ps
module sreg_front_model #(
   parameter int DLY = 20
) (
   // Clock, reset and launch.
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          meas_i,
   input  wire logic [15:0]   value_i,
   // Result.
   output sreg_pkg::sreg_result_t res_o
);
   import sreg_pkg::*;
   int cnt = 0;
   // Conversion time; restarts for each measurement so continuous runs repeat.
   always @(posedge clk_i) begin
      cnt <= (rst_i || !meas_i || res_o.done) ? 0 : cnt + 1;
   end
   // Data off the pulse keeps changing, so an early latch shows up.
   assign res_o = '{done: cnt == DLY, data: (cnt == DLY) ? value_i : ~value_i ^ 16'(cnt)};
endmodule

// ---- dv/sreg_top_checker.sv ----
`timescale 1ns/1ps
module sreg_top_checker #(
   parameter logic [15:0] PART_CODE = 16'hA5C3
) (
   // Clock and reset.
   input wire logic                MCLK_I,
   input wire logic                RST_I,
   // Register port and status.
   input wire sreg_pkg::sreg_req_t REG_REQ_I,
   input wire logic [7:0]          REG_RDATA_O,
   input wire logic                REG_RVALID_O,
   input wire logic                T_MEAS_O,
   input wire logic                H_MEAS_O,
   input wire logic                SYSTEM_ACTIVE_FLAG_O
);
   import sreg_pkg::*;
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (RST_I);
   logic [7:0] ad;
   logic       hi;
   logic       rd;
   // Short names keep the properties readable.
   assign ad = REG_REQ_I.addr;
   assign hi = REG_REQ_I.addr[0];
   assign rd = REG_REQ_I.rd;
   ////////////////////////////////////////
   property p_rd_ans; rd |=> REG_RVALID_O; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("Read not answered.");
   property p_id_hid; rd && (ad < 8'h02 || (ad > 8'h03 && ad < 8'h0C)) && !SYSTEM_ACTIVE_FLAG_O |=> REG_RDATA_O == 8'h00;
   endproperty
   a_id_hid: assert property (p_id_hid) else $error("Identifier seen out of active.");
   property p_part; rd && ad < 8'h02 && SYSTEM_ACTIVE_FLAG_O |=> REG_RDATA_O == ($past(hi) ? PART_CODE[15:8] : PART_CODE[7:0]);
   endproperty
   a_part: assert property (p_part) else $error("Part code byte wrong.");
   property p_stat; rd && ad == 8'h11 |=> REG_RDATA_O == {7'h00, $past(SYSTEM_ACTIVE_FLAG_O)}; endproperty
   a_stat: assert property (p_stat) else $error("System status wrong.");
   property p_sens; rd && ad == 8'h24 |=> REG_RDATA_O == {6'h00, $past(H_MEAS_O), $past(T_MEAS_O)}; endproperty
   a_sens: assert property (p_sens) else $error("Sensor status wrong.");
   property p_wo; rd && (ad == 8'h22 || ad == 8'h23) |=> REG_RDATA_O == 8'h00; endproperty
   a_wo: assert property (p_wo) else $error("Write-only byte read back.");
   property p_start; REG_REQ_I.wr && ad == 8'h22 && REG_REQ_I.wdata[0] && SYSTEM_ACTIVE_FLAG_O && !T_MEAS_O
      |-> ##2 (T_MEAS_O || !SYSTEM_ACTIVE_FLAG_O); endproperty
   a_start: assert property (p_start) else $error("Start did not launch.");
   property p_soft; REG_REQ_I.wr && ad == 8'h10 && REG_REQ_I.wdata[7]
      |-> ##[1:2] (!T_MEAS_O && !H_MEAS_O && SYSTEM_ACTIVE_FLAG_O); endproperty
   a_soft: assert property (p_soft) else $error("Soft reset missed.");
endmodule
bind sreg_top sreg_top_checker #(.PART_CODE(PART_CODE)) u_chk (.MCLK_I(MCLK_I), .RST_I(RST_I),
   .REG_REQ_I(REG_REQ_I), .REG_RDATA_O(REG_RDATA_O), .REG_RVALID_O(REG_RVALID_O), .T_MEAS_O(T_MEAS_O),
   .H_MEAS_O(H_MEAS_O), .SYSTEM_ACTIVE_FLAG_O(SYSTEM_ACTIVE_FLAG_O));

// ---- dv/test_sensor_system_register_map.sv ----
`timescale 1ns/1ps
module test_sensor_system_register_map;
   import sreg_pkg::*;
   localparam logic [15:0] PCODE = 16'h5A3C;            // Arbitrary value.
   localparam logic [63:0] UCODE = 64'hF0E1D2C3B4A59687; // Arbitrary value.
   localparam logic [47:0] VALS  = 48'hF52E6C0B49FD;
   logic         clk = 1'b0;
   logic         rst = 1'b1;
   sreg_req_t    req = '0;
   sreg_result_t t_res, h_res;
   logic [7:0]   rdata;
   logic         rvalid, t_meas, h_meas, act;
   int           miscompares = 0;
   int           n_compared = 0;
   int           cyc = 0;
   always #2.5 clk = ~clk;
   sreg_top #(.PART_CODE(PCODE), .UID_VALUE(UCODE), .BOOT_CYC(2)) dut (.MCLK_I(clk), .RST_I(rst),
      .REG_REQ_I(req), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .T_RES_I(t_res), .H_RES_I(h_res),
      .T_MEAS_O(t_meas), .H_MEAS_O(h_meas), .SYSTEM_ACTIVE_FLAG_O(act));
   sreg_front_model #(.DLY(20)) t_fe (.clk_i(clk), .rst_i(rst), .meas_i(t_meas), .value_i(16'h49FD), .res_o(t_res));
   sreg_front_model #(.DLY(30)) h_fe (.clk_i(clk), .rst_i(rst), .meas_i(h_meas), .value_i(16'h2E6C), .res_o(h_res));
   ////////////////////////////////////////
   task automatic give_verdict();
      $display("Compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Bus tasks start and end just after an edge; the request holds for one edge.
   // An idle edge follows each release so the next call never re-raises the strobe in the same step.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      @(posedge clk);
      #1 req.wr = 1'b0;
      @(posedge clk);
      #1;
   endtask
   // The answer stands for one cycle only, right after the edge that took the read.
   task automatic rd_raw(input logic [7:0] a, output logic [8:0] v);
      req.rd = 1'b1;
      req.addr = a;
      @(posedge clk);
      #1 v = {rvalid, rdata};
      req.rd = 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [8:0] v;
      rd_raw(a, v);
      chk(v, {1'b1, e});
   endtask
   // Polling is bounded so a stuck status ends in a mismatch.
   task automatic poll(input logic [7:0] a, input logic [7:0] e);
      logic [8:0] v;
      repeat (60) begin
         rd_raw(a, v);
         if (v[7:0] === e) break;
      end
      chk(v, {1'b1, e});
   endtask
   ////////////////////////////////////////
   task automatic t_reset();
      rd(8'h11, 8'h01);
      rd(8'h11, 8'h00);
      rd(8'h10, 8'h01);
      rd(8'h21, 8'h00);
      rd(8'h00, 8'h00);
      rd(8'h07, 8'h00);
   endtask
   task automatic t_dedicated();
      wr(8'h10, 8'h00);
      poll(8'h11, 8'h01);
      for (int i = 0; i < 2; i++) rd(8'(i), PCODE[8*i +: 8]);
      rd(8'h02, 8'h00);
      for (int i = 0; i < 8; i++) rd(8'h04 + 8'(i), UCODE[8*i +: 8]);
      wr(8'h22, 8'h00);
      rd(8'h24, 8'h00);
      wr(8'h22, 8'h01);
      repeat (2) @(posedge clk);
      #1 rd(8'h24, 8'h01);
      poll(8'h24, 8'h00);
      for (int i = 0; i < 3; i++) rd(8'h30 + 8'(i), VALS[8*i +: 8]);
      rd(8'h11, 8'h01);
      wr(8'h10, 8'h01);
      poll(8'h11, 8'h00);
   endtask
   task automatic t_piggy();
      wr(8'h22, 8'h03);
      poll(8'h11, 8'h01);
      rd(8'h01, PCODE[15:8]);
      rd(8'h11, 8'h01);
      rd(8'h22, 8'h00);
      rd(8'h23, 8'h00);
      poll(8'h24, 8'h00);
      for (int i = 0; i < 6; i++) rd(8'h30 + 8'(i), VALS[8*i +: 8]);
      poll(8'h11, 8'h00);
   endtask
   task automatic t_soft();
      wr(8'h21, 8'h03);
      rd(8'h21, 8'h03);
      wr(8'h10, 8'h00);
      // Continuous temperature runs past one conversion until a stop lands.
      wr(8'h22, 8'h01);
      repeat (30) @(posedge clk);
      #1 rd(8'h24, 8'h01);
      wr(8'h23, 8'h01);
      poll(8'h24, 8'h00);
      wr(8'h10, 8'h80);
      repeat (2) @(posedge clk);
      #1 rd(8'h21, 8'h00);
      rd(8'h10, 8'h01);
   endtask
   // Main sequence after a three-cycle reset.
   initial begin
      repeat (3) @(posedge clk);
      #1 rst = 1'b0;
      t_reset();
      t_dedicated();
      t_piggy();
      t_soft();
      give_verdict();
   end
   // A hung run is cut short well above the expected length.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         miscompares++;
         give_verdict();
      end
   end
endmodule

// ---- hw/sreg_pkg.sv ----
// How it works
// R01 - Identifier bytes read back only while the power state is active, else zero.
// R02 - Host clears low power, polls active, reads identifiers, restores low power.
// R03 - Host may instead start a measurement, read identifiers, then recheck active.
// R04 - Multi-byte registers sit on consecutive byte addresses, each byte addressable.
// R05 - Control, status, run, start, stop, sensor status and readouts decode at fixed addresses.
// R06 - Start and stop are write-only; sensor status is read-only idle/measuring per sensor.
// R07 - A fixed 16-bit part code reads over two bytes, low byte first.
// R08 - A per-device 64-bit identifier reads as eight read-only bytes from its base.
// R09 - Writing one to control bit 7 resets the whole block; bit reads zero.
// R10 - Control bit 0, default one, returns the block to standby after measuring.
// R11 - Status bit 0 is one when active, zero in standby or booting; default one.
// R12 - Run bit 0 selects temperature single shot or continuous, default single shot.
// R13 - Run bit 1 selects humidity single shot or continuous, default single shot.
// R14 - Start bit 0 starts temperature, bit 1 starts humidity; zeros have no effect.
// R15 - Host writes zeros to reserved bits and ignores reserved address ranges.
// R16 - After soft reset all writable controls take their default values.
package sreg_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Byte address map.
   localparam logic [7:0] ADDR_PART_IDENTIFIER  = 8'h00;
   localparam logic [7:0] ADDR_UID      = 8'h04;
   localparam logic [7:0] ADDR_SYSTEM_CONTROL = 8'h10;
   localparam logic [7:0] ADDR_SYSTEM_STATUS = 8'h11;
   localparam logic [7:0] ADDR_RUN      = 8'h21;
   localparam logic [7:0] ADDR_START    = 8'h22;
   localparam logic [7:0] ADDR_STOP     = 8'h23;
   localparam logic [7:0] ADDR_SSTAT    = 8'h24;
   localparam logic [7:0] ADDR_T_VAL    = 8'h30;
   localparam logic [7:0] ADDR_H_VAL    = 8'h33;
   localparam logic [7:0] PART_BYTES    = 8'h02;
   localparam logic [7:0] UID_BYTES     = 8'h08;
   localparam logic [7:0] VAL_BYTES     = 8'h03;

   ////////////////////////////////////////////////////////////////////////////////
   // Field positions and reset values.
   localparam int         CTRL_RESET_BIT = 7;
   localparam int         CTRL_LP_BIT    = 0;
   localparam int         T_BIT          = 0;
   localparam int         H_BIT          = 1;
   localparam logic       LP_RST         = 1'b1;
   localparam logic [1:0] RUN_RST        = 2'b00;
   localparam logic [7:0] BYTE_ZERO      = 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // Timing; booting time is a plain default.
   localparam int CLK_PERIOD_PS = 5000;
   localparam int BOOT_TIME_NS  = 1000;
   localparam int BOOT_CYCLES   = (BOOT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // Readout checksum constants.
   localparam logic [7:0] CRC7_POLY = 8'h89;
   localparam logic [6:0] CRC7_IVEC = 7'h7F;

   ////////////////////////////////////////////////////////////////////////////////
   // Carriers and states.
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sreg_req_t;

   typedef struct packed {
      logic        done;
      logic [15:0] data;
   } sreg_result_t;

   typedef enum logic [1:0] {PWR_STANDBY, PWR_BOOTING, PWR_ACTIVE} sreg_pwr_t;

   // Checksum over data and valid flag, initial vector all ones.
   function automatic logic [6:0] crc7(input logic [16:0] payload);
      logic [23:0] val;
      logic [23:0] pol;
      val = {payload, CRC7_IVEC};
      pol = {CRC7_POLY, 16'h0000};
      for (int i = 23; i >= 7; i--) begin
         if (val[i]) begin
            val = val ^ pol;
         end
         pol = pol >> 1;
      end
      return val[6:0];
   endfunction

   // Byte lane of a wide value.
   function automatic logic [7:0] pick_byte(input logic [63:0] v, input logic [2:0] idx);
      return v[{idx, 3'b000} +: 8];
   endfunction

endpackage

// ---- hw/sreg_top.sv ----
`timescale 1ns/1ps
module sreg_top #(
   parameter logic [15:0] PART_CODE = 16'hA5C3,                 // Arbitrary value.
   parameter logic [63:0] UID_VALUE = 64'h0123_4567_89AB_CDEF,  // Arbitrary value.
   parameter int          BOOT_CYC  = sreg_pkg::BOOT_CYCLES
) (
   // Clock and reset.
   input  wire logic                   MCLK_I,
   input  wire logic                   RST_I,
   // Byte register port from the serial command interpreter.
   input  wire sreg_pkg::sreg_req_t    REG_REQ_I,
   output logic [7:0]                  REG_RDATA_O,
   output logic                        REG_RVALID_O,
   // Sensor front ends.
   input  wire sreg_pkg::sreg_result_t T_RES_I,
   input  wire sreg_pkg::sreg_result_t H_RES_I,
   output logic                        T_MEAS_O,
   output logic                        H_MEAS_O,
   output logic                        SYSTEM_ACTIVE_FLAG_O
);
   import sreg_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // State.
   sreg_pwr_t   pwr_q, pwr_d;
   logic [15:0] boot_cnt_q, boot_cnt_d;
   logic        lp_q, lp_d;
   logic        soft_q, soft_d;
   logic [1:0]  run_q, run_d;
   logic [1:0]  pend_q, pend_d;
   logic [1:0]  stop_q, stop_d;
   logic [1:0]  meas_q, meas_d;
   logic [1:0]  valid_q, valid_d;
   logic [15:0] tdat_q, tdat_d;
   logic [15:0] hdat_q, hdat_d;
   logic [23:0] tbuf_q, tbuf_d;
   logic [23:0] hbuf_q, hbuf_d;
   logic [7:0]  rdata_q, rdata_d;
   logic        rvalid_q, rvalid_d;

   logic [23:0] t_live;
   logic [23:0] h_live;
   logic [1:0]  done;
   logic        want_active;
   logic [7:0]  off;

   ////////////////////////////////////////////////////////////////////////////////
   // Live readout words: checksum, valid flag, data.
   assign t_live = {crc7({valid_q[T_BIT], tdat_q}), valid_q[T_BIT], tdat_q};
   assign h_live = {crc7({valid_q[H_BIT], hdat_q}), valid_q[H_BIT], hdat_q};
   assign done   = {H_RES_I.done & meas_q[H_BIT], T_RES_I.done & meas_q[T_BIT]};

   // The block stays awake while low power is off or any sensor has work.
   assign want_active = ~lp_q | (|pend_q) | (|meas_q);  // [R10]

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic for power, control, measurement and readback.
   always_comb begin
      pwr_d      = pwr_q;
      boot_cnt_d = boot_cnt_q;
      lp_d       = lp_q;
      soft_d     = 1'b0;
      run_d      = run_q;
      pend_d     = pend_q;
      stop_d     = stop_q;
      meas_d     = meas_q;
      valid_d    = valid_q;
      tdat_d     = tdat_q;
      hdat_d     = hdat_q;
      tbuf_d     = tbuf_q;
      hbuf_d     = hbuf_q;
      rdata_d    = rdata_q;
      rvalid_d   = REG_REQ_I.rd;
      off        = BYTE_ZERO;

      // Power state; status reads active only in the active state.
      unique case (pwr_q)
         PWR_STANDBY: begin
            if (want_active) begin
               pwr_d      = PWR_BOOTING;
               boot_cnt_d = 16'h0000;
            end
         end
         PWR_BOOTING: begin
            boot_cnt_d = boot_cnt_q + 16'h0001;
            if (boot_cnt_q >= 16'(BOOT_CYC - 1)) begin
               pwr_d = PWR_ACTIVE;  // [R11]
            end
         end
         PWR_ACTIVE: begin
            if (!want_active) begin
               pwr_d = PWR_STANDBY;  // [R10]
            end
         end
      endcase

      // Measurement completion; continuous mode restarts unless a stop is pending.
      if (done[T_BIT]) begin
         tdat_d         = T_RES_I.data;
         valid_d[T_BIT] = 1'b1;
      end
      if (done[H_BIT]) begin
         hdat_d         = H_RES_I.data;
         valid_d[H_BIT] = 1'b1;
      end
      for (int s = 0; s < 2; s++) begin
         if (done[s]) begin
            if (!(run_q[s] && !stop_q[s])) begin  // [R12] [R13]
               meas_d[s] = 1'b0;
               stop_d[s] = 1'b0;
            end
         end
         // Pending starts launch only once awake; valid clears on launch.
         if (pend_q[s] && !meas_q[s] && pwr_q == PWR_ACTIVE) begin  // [R14]
            meas_d[s]  = 1'b1;
            pend_d[s]  = 1'b0;
            valid_d[s] = 1'b0;
         end
      end

      // Register writes; a set from a write wins over any same-cycle clear.
      if (REG_REQ_I.wr) begin
         unique case (REG_REQ_I.addr)
            ADDR_SYSTEM_CONTROL: begin
               lp_d   = REG_REQ_I.wdata[CTRL_LP_BIT];     // [R10]
               soft_d = REG_REQ_I.wdata[CTRL_RESET_BIT];  // [R09]
            end
            ADDR_RUN: begin
               run_d = REG_REQ_I.wdata[1:0];  // [R12] [R13]
            end
            ADDR_START: begin
               pend_d = pend_d | REG_REQ_I.wdata[1:0];  // [R14] [R06]
            end
            ADDR_STOP: begin
               stop_d = stop_d | REG_REQ_I.wdata[1:0];  // [R06]
            end
            default: begin
            end
         endcase
      end

      // Register reads; unmapped and write-only bytes read zero.
      if (REG_REQ_I.rd) begin
         rdata_d = BYTE_ZERO;
         if (REG_REQ_I.addr < ADDR_PART_IDENTIFIER + PART_BYTES) begin
            off = REG_REQ_I.addr - ADDR_PART_IDENTIFIER;
            if (pwr_q == PWR_ACTIVE) begin  // [R01]
               rdata_d = pick_byte({48'h0, PART_CODE}, off[2:0]);  // [R07] [R04]
            end
         end else if (REG_REQ_I.addr >= ADDR_UID && REG_REQ_I.addr < ADDR_UID + UID_BYTES) begin
            off = REG_REQ_I.addr - ADDR_UID;
            if (pwr_q == PWR_ACTIVE) begin  // [R01]
               rdata_d = pick_byte(UID_VALUE, off[2:0]);  // [R08] [R04]
            end
         end else if (REG_REQ_I.addr >= ADDR_T_VAL && REG_REQ_I.addr < ADDR_T_VAL + VAL_BYTES) begin
            off = REG_REQ_I.addr - ADDR_T_VAL;
            // Reading the first byte snapshots the whole word for a consistent view.
            if (off == BYTE_ZERO) begin
               tbuf_d  = t_live;
               rdata_d = t_live[7:0];
            end else begin
               rdata_d = pick_byte({40'h0, tbuf_q}, off[2:0]);  // [R04]
            end
         end else if (REG_REQ_I.addr >= ADDR_H_VAL && REG_REQ_I.addr < ADDR_H_VAL + VAL_BYTES) begin
            off = REG_REQ_I.addr - ADDR_H_VAL;
            if (off == BYTE_ZERO) begin
               hbuf_d  = h_live;
               rdata_d = h_live[7:0];
            end else begin
               rdata_d = pick_byte({40'h0, hbuf_q}, off[2:0]);  // [R04]
            end
         end else begin
            unique case (REG_REQ_I.addr)  // [R05]
               ADDR_SYSTEM_CONTROL: rdata_d = {7'h00, lp_q};
               ADDR_SYSTEM_STATUS: rdata_d = {7'h00, pwr_q == PWR_ACTIVE};  // [R11]
               ADDR_RUN:      rdata_d = {6'h00, run_q};
               ADDR_SSTAT:    rdata_d = {6'h00, meas_q};  // [R06]
               default:       rdata_d = BYTE_ZERO;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers; the soft reset pulse re-applies every default one cycle later.
   always_ff @(posedge MCLK_I) begin
      if (RST_I || soft_q) begin  // [R09] [R16]
         pwr_q      <= PWR_ACTIVE;
         boot_cnt_q <= 16'h0000;
         lp_q       <= LP_RST;
         soft_q     <= 1'b0;
         run_q      <= RUN_RST;
         pend_q     <= 2'b00;
         stop_q     <= 2'b00;
         meas_q     <= 2'b00;
         valid_q    <= 2'b00;
         tdat_q     <= 16'h0000;
         hdat_q     <= 16'h0000;
         tbuf_q     <= 24'h000000;
         hbuf_q     <= 24'h000000;
         rdata_q    <= 8'h00;
         rvalid_q   <= 1'b0;
      end else begin
         pwr_q      <= pwr_d;
         boot_cnt_q <= boot_cnt_d;
         lp_q       <= lp_d;
         soft_q     <= soft_d;
         run_q      <= run_d;
         pend_q     <= pend_d;
         stop_q     <= stop_d;
         meas_q     <= meas_d;
         valid_q    <= valid_d;
         tdat_q     <= tdat_d;
         hdat_q     <= hdat_d;
         tbuf_q     <= tbuf_d;
         hbuf_q     <= hbuf_d;
         rdata_q    <= rdata_d;
         rvalid_q   <= rvalid_d;
      end
   end

   // Outputs straight from flip-flops, except the active flag, which is decoded from the power state.
   assign REG_RDATA_O  = rdata_q;
   assign REG_RVALID_O = rvalid_q;
   assign T_MEAS_O     = meas_q[T_BIT];
   assign H_MEAS_O     = meas_q[H_BIT];
   assign SYSTEM_ACTIVE_FLAG_O = (pwr_q == PWR_ACTIVE);

endmodule
